/* File: gap_match_pkg.sv */
// Constants for the receive character gap timer and match comparator
package gap_match_pkg;
    // --------------------------------------------------------------
    // Register byte addresses
    // --------------------------------------------------------------
    localparam logic [31:0] ADDR_GAP_TIMER = 32'h9020_0018;
    localparam logic [31:0] ADDR_MATCH = 32'h9020_001c;
    localparam logic [31:0] ADDR_MASK = 32'h9020_0020;
    localparam logic [31:0] ADDR_FLOW_CTRL = 32'h9020_0024;
    // --------------------------------------------------------------
    // Field layout
    // --------------------------------------------------------------
    localparam int GAP_ENABLE_BIT = 31;
    localparam int GAP_THRESH_W = 20;
    localparam logic [19:0] GAP_THRESH_MAX = 20'h7_ffff;
    localparam int NUM_ENTRIES = 4;
    localparam int BYTE_W = 8;
    localparam int ACTION_W = 2;
    localparam int FLOW_STATE_LSB = 8;
    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [31:0] GAP_TIMER_RESET = 32'h0000_0000;
    localparam logic [31:0] MATCH_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [7:0] ACTIONS_RESET = 8'haa;
    localparam logic [1:0] FLOW_STATE_RESET = 2'h2;
    // --------------------------------------------------------------
    // Flow actions and timing
    // --------------------------------------------------------------
    localparam logic [1:0] ACTION_HW_XON = 2'h2;
    localparam logic [1:0] ACTION_HW_XOFF = 2'h3;
    localparam int CLK_PERIOD_NS = 40;
    localparam int GAP_TICK_DIV = 4;
    localparam logic [1:0] PRESCALE_LAST = 2'(GAP_TICK_DIV - 1);
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

/* File: rx_char_source.sv */
// Behavioural remote serial source handing over received characters
`timescale 1ns/1ps
module rx_char_source (
    input wire logic hclk,
    output logic rx_char_valid,
    output logic [7:0] rx_char_data
);
    initial begin
        rx_char_valid = 1'b0;
        rx_char_data = 8'h00;
    end
    // One pulse per whole character, then idle
    task automatic send(input logic [7:0] c);
        rx_char_valid <= 1'b1;
        rx_char_data <= c;
        @(posedge hclk);
        rx_char_valid <= 1'b0;
        // Idle data is not held, so a stale byte cannot look valid
        rx_char_data <= ~c;
    endtask
endmodule

/* File: uart_rx_gap_timer_match.sv */
// Receive character gap timer and four-entry receive match comparator
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// --------------------------------------------------------------
// Notes on behaviour
// - Each received character restarts the gap timer
// - Threshold reached closes the current receive buffer
// - Bit 31 enables timer, resets to zero
// - Threshold is bits 19:0, max 0x7FFFF
// - Tick every four clocks, expire after threshold+1
// - Timer runs on divided system oscillator clock
// - Interval spans roughly 0.16us to 0.084s
// - Four match bytes, byte one highest, reset zero
// - Mask bit one excludes that bit position
// - Mask byte n pairs with match byte n
// - Entry action 10/11 sets XON/XOFF on match
// --------------------------------------------------------------
module uart_rx_gap_timer_match (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    output logic buffer_close,
    output logic [3:0] match_hit,
    output logic [1:0] flow_state
);
    // --------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------
    logic gap_timer_enable;
    logic [19:0] char_gap_threshold;
    logic [31:0] match_bytes;
    logic [31:0] mask_bytes;
    logic [7:0] match_actions;
    logic wr_pending;
    logic [31:0] wr_addr;
    logic addr_phase;
    logic [31:0] next_rdata;

    // Address phase counts only while the bus is ready; idle cycles are ignored
    assign addr_phase = hsel && hready && htrans == gap_match_pkg::HTRANS_NONSEQ;

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Writes land one edge later, once hwdata stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr <= gap_match_pkg::READ_ZERO;
        end else begin
            wr_pending <= addr_phase && hwrite;
            wr_addr <= haddr;
        end
    end

    // Unmapped addresses read zero; unused gap bits read zero
    always_comb begin
        next_rdata = gap_match_pkg::READ_ZERO;
        if (haddr == gap_match_pkg::ADDR_GAP_TIMER) begin
            next_rdata[gap_match_pkg::GAP_ENABLE_BIT] = gap_timer_enable;
            next_rdata[19:0] = char_gap_threshold;
        end else if (haddr == gap_match_pkg::ADDR_MATCH) begin
            next_rdata = match_bytes;
        end else if (haddr == gap_match_pkg::ADDR_MASK) begin
            next_rdata = mask_bytes;
        end else if (haddr == gap_match_pkg::ADDR_FLOW_CTRL) begin
            next_rdata[7:0] = match_actions;
            next_rdata[9:8] = flow_state;
        end
    end

    // Read data launches at the address edge and stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= gap_match_pkg::READ_ZERO;
        end else if (addr_phase && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Threshold above the software limit is stored as written
    // gap register fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_timer_enable <= gap_match_pkg::GAP_TIMER_RESET[31];
            char_gap_threshold <= gap_match_pkg::GAP_TIMER_RESET[19:0];
        end else if (wr_pending && wr_addr == gap_match_pkg::ADDR_GAP_TIMER) begin
            gap_timer_enable <= hwdata[gap_match_pkg::GAP_ENABLE_BIT];
            char_gap_threshold <= hwdata[19:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_bytes <= gap_match_pkg::MATCH_RESET;
            mask_bytes <= gap_match_pkg::MASK_RESET;
        end else if (wr_pending && wr_addr == gap_match_pkg::ADDR_MATCH) begin
            match_bytes <= hwdata;
        end else if (wr_pending && wr_addr == gap_match_pkg::ADDR_MASK) begin
            mask_bytes <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_actions <= gap_match_pkg::ACTIONS_RESET;
        end else if (wr_pending && wr_addr == gap_match_pkg::ADDR_FLOW_CTRL) begin
            match_actions <= hwdata[7:0];
        end
    end

    // --------------------------------------------------------------
    // Character gap timer
    // --------------------------------------------------------------
    // hclk is the divided oscillator clock; range follows from width
    logic [1:0] prescale;
    logic [19:0] gap_cnt;
    logic armed;
    logic tick;
    logic expire;

    // A zero threshold closes four clocks after the character
    assign tick = prescale == gap_match_pkg::PRESCALE_LAST;
    // A character in the expiry cycle wins: restart rather than close
    assign expire = gap_timer_enable && armed && tick && gap_cnt == char_gap_threshold && !rx_char_valid;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale <= 2'h0;
        end else if (!gap_timer_enable || rx_char_valid) begin
            prescale <= 2'h0;
        end else begin
            prescale <= prescale + 2'h1;
        end
    end

    // restart on character, hold zero when disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_cnt <= 20'h0_0000;
            armed <= 1'b0;
        end else if (!gap_timer_enable) begin
            gap_cnt <= 20'h0_0000;
            armed <= 1'b0;
        end else if (rx_char_valid) begin
            gap_cnt <= 20'h0_0000;
            armed <= 1'b1;
        end else if (expire) begin
            gap_cnt <= 20'h0_0000;
            armed <= 1'b0;
        end else if (armed && tick) begin
            gap_cnt <= gap_cnt + 20'h0_0001;
        end
    end

    // close buffer once, on the threshold+1 tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buffer_close <= 1'b0;
        end else begin
            buffer_close <= expire;
        end
    end

    // --------------------------------------------------------------
    // Match comparator
    // --------------------------------------------------------------
    logic [3:0] entry_eq;
    logic [1:0] next_flow;

    // Masked compare, shared by every entry and by the second and third entry checks below
    function automatic logic masked_hit(input logic [7:0] c, input logic [7:0] pat, input logic [7:0] msk);
        masked_hit = ((c ^ pat) & ~msk) == 8'h00;
    endfunction

    // match_hit bit i reports entry i+1, whose byte sits in the top lane first
    // masked compare, every entry in parallel
    for (genvar i = 0; i < gap_match_pkg::NUM_ENTRIES; i++) begin : g_entry
        localparam int HI = 31 - i * gap_match_pkg::BYTE_W;
        assign entry_eq[i] = masked_hit(rx_char_data, match_bytes[HI -: 8], mask_bytes[HI -: 8]);
    end

    // Registered so match_hit lines up with flow_state one edge after the character

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_hit <= 4'h0;
        end else begin
            match_hit <= rx_char_valid ? entry_eq : 4'h0;
        end
    end

    // first enabled matching entry wins; hardware beats software write
    always_comb begin
        next_flow = flow_state;
        if (wr_pending && wr_addr == gap_match_pkg::ADDR_FLOW_CTRL) begin
            next_flow = hwdata[9:8];
        end
        if (rx_char_valid) begin
            for (int k = gap_match_pkg::NUM_ENTRIES - 1; k >= 0; k--) begin
                if (entry_eq[k] && match_actions[2 * k + 1]) begin
                    next_flow = match_actions[2 * k +: 2];
                end
            end
        end
    end

    // Software may force any state; the next enabled match overrides it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flow_state <= gap_match_pkg::FLOW_STATE_RESET;
        end else begin
            flow_state <= next_flow;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    disabled_holds_zero_a: assert property (!gap_timer_enable |=> gap_cnt == 20'h0_0000 && !buffer_close)
        else $error("gap counter not held while disabled");
    char_restart_a: assert property (gap_timer_enable && rx_char_valid |=> gap_cnt == 20'h0_0000 && prescale == 2'h0)
        else $error("character did not restart gap timer");
    close_cause_a: assert property (buffer_close |-> $past(armed) && $past(gap_cnt) == $past(char_gap_threshold))
        else $error("buffer closed without reaching threshold");
    tick_spacing_a: assert property (tick |=> !tick ##1 !tick ##1 !tick)
        else $error("gap tick faster than every four clocks");
    enable_write_a: assert property (wr_pending && wr_addr == gap_match_pkg::ADDR_GAP_TIMER
        |=> gap_timer_enable == $past(hwdata[31]) && char_gap_threshold == $past(hwdata[19:0]))
        else $error("gap register write not taken");
    first_entry_hit_a: assert property (rx_char_valid
        && ((rx_char_data ^ match_bytes[31:24]) & ~mask_bytes[31:24]) == 8'h00 |=> match_hit[0])
        else $error("masked match on first entry missed");
    fourth_entry_miss_a: assert property (rx_char_valid
        && ((rx_char_data ^ match_bytes[7:0]) & ~mask_bytes[7:0]) != 8'h00 |=> !match_hit[3])
        else $error("fourth entry matched on unmasked difference");
    xoff_set_a: assert property (rx_char_valid && entry_eq[0]
        && match_actions[1:0] == gap_match_pkg::ACTION_HW_XOFF |=> flow_state == gap_match_pkg::ACTION_HW_XOFF)
        else $error("first entry match did not set XOFF");
    disabled_entries_a: assert property (rx_char_valid && !match_actions[1] && !match_actions[3]
        && !match_actions[5] && !match_actions[7] && !wr_pending |=> $stable(flow_state))
        else $error("disabled entries changed flow state");
    close_once_a: assert property (buffer_close |=> !buffer_close ##1 !buffer_close)
        else $error("buffer closed twice without new character");

    gap_read_fields_a: assert property (addr_phase && !hwrite && haddr == gap_match_pkg::ADDR_GAP_TIMER
        |=> hrdata[30:20] == 11'h000 && hrdata[19:0] == $past(char_gap_threshold))
        else $error("gap register read shows unused bits or a stale threshold");
    match_read_a: assert property (addr_phase && !hwrite && haddr == gap_match_pkg::ADDR_MATCH
        |=> hrdata == $past(match_bytes))
        else $error("match register read differs from stored bytes");
    mask_write_a: assert property (wr_pending && wr_addr == gap_match_pkg::ADDR_MASK
        |=> mask_bytes == $past(hwdata))
        else $error("mask register write not taken");
    prescale_hold_a: assert property (!gap_timer_enable |=> prescale == 2'h0 && !armed)
        else $error("prescaler or arm not cleared while disabled");
    second_entry_hit_a: assert property (rx_char_valid
        && masked_hit(rx_char_data, match_bytes[23:16], mask_bytes[23:16]) |=> match_hit[1])
        else $error("second entry missed a masked match");
    third_entry_miss_a: assert property (rx_char_valid
        && !masked_hit(rx_char_data, match_bytes[15:8], mask_bytes[15:8]) |=> !match_hit[2])
        else $error("third entry matched on an unmasked difference");
    idle_no_hit_a: assert property (!rx_char_valid |=> match_hit == 4'h0)
        else $error("match reported without a character");
    flow_xon_a: assert property (rx_char_valid && entry_eq == 4'h8
        && match_actions[7:6] == gap_match_pkg::ACTION_HW_XON |=> flow_state == gap_match_pkg::ACTION_HW_XON)
        else $error("lone fourth entry match did not set XON");
    flow_write_a: assert property (wr_pending && wr_addr == gap_match_pkg::ADDR_FLOW_CTRL && !rx_char_valid
        |=> flow_state == $past(hwdata[9:8]))
        else $error("software flow state write not taken");

    // --------------------------------------------------------------
    // Cover properties
    // --------------------------------------------------------------
    close_seen_c: cover property (rx_char_valid ##[1:40] buffer_close);
    xoff_seen_c: cover property (rx_char_valid && entry_eq[2] && match_actions[5:4] == gap_match_pkg::ACTION_HW_XOFF);
    restart_seen_c: cover property (armed && gap_cnt != 20'h0_0000 && rx_char_valid);
    xon_seen_c: cover property (rx_char_valid && entry_eq[3] && match_actions[7:6] == gap_match_pkg::ACTION_HW_XON);
    disabled_char_c: cover property (!gap_timer_enable && rx_char_valid);
endmodule

/* File: uart_rx_gap_timer_match_bench.sv */
// Self-checking bench for the gap timer and match comparator
`timescale 1ns/1ps
module uart_rx_gap_timer_match_bench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_char_valid, buffer_close;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, flow_state;
    logic [2:0] hsize;
    logic [7:0] rx_char_data;
    logic [3:0] match_hit;
    int error_cnt = 0;
    int num_checks = 0;
    int closes = 0;
    assign hready = hreadyout;
    uart_rx_gap_timer_match i_uart_rx_gap_timer_match (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .buffer_close(buffer_close), .match_hit(match_hit),
        .flow_state(flow_state));
    rx_char_source i_rx_char_source (.hclk(hclk), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) if (buffer_close === 1'b1) closes <= closes + 1;
    // --------------------------------------------------------------
    // Bus and compare helpers
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= gap_match_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        check(r, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        rd_chk(gap_match_pkg::ADDR_GAP_TIMER, gap_match_pkg::GAP_TIMER_RESET);
        rd_chk(gap_match_pkg::ADDR_MATCH, gap_match_pkg::MATCH_RESET);
        rd_chk(gap_match_pkg::ADDR_MASK, gap_match_pkg::MASK_RESET);
        rd_chk(gap_match_pkg::ADDR_FLOW_CTRL, 32'({gap_match_pkg::FLOW_STATE_RESET,
            gap_match_pkg::ACTIONS_RESET}));
        rd_chk(32'h9020_0028, gap_match_pkg::READ_ZERO);
        check(32'(flow_state), 32'(gap_match_pkg::FLOW_STATE_RESET));
        check(32'(hreadyout), 32'h0000_0001);
        check(32'(hresp), 32'h0000_0000);
    endtask
    task automatic t_regs;
        wr(gap_match_pkg::ADDR_GAP_TIMER, 32'h8007_ffff);
        rd_chk(gap_match_pkg::ADDR_GAP_TIMER, 32'h8007_ffff);
        wr(gap_match_pkg::ADDR_MATCH, 32'h4142_4344);
        rd_chk(gap_match_pkg::ADDR_MATCH, 32'h4142_4344);
        wr(gap_match_pkg::ADDR_MASK, 32'h0000_000f);
        rd_chk(gap_match_pkg::ADDR_MASK, 32'h0000_000f);
    endtask
    task automatic t_gap(input logic [19:0] th, input bit restart);
        int n;
        int c0;
        // short threshold, reserved bits left zero
        wr(gap_match_pkg::ADDR_GAP_TIMER, {12'h800, th});
        c0 = closes;
        if (restart) begin
            i_rx_char_source.send(8'h10);
            repeat (8) @(posedge hclk);
        end
        i_rx_char_source.send(8'h11);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (buffer_close !== 1'b1 && n < 80);
        // Pulse registered at the expiry edge is seen at the following edge
        check(32'(n), 32'((th + 1) * 4 + 1));
        repeat (40) @(posedge hclk);
        check(32'(closes - c0), 32'h0000_0001);
    endtask
    task automatic t_disabled;
        int c0;
        wr(gap_match_pkg::ADDR_GAP_TIMER, 32'h0000_0003);
        c0 = closes;
        i_rx_char_source.send(8'h11);
        repeat (40) @(posedge hclk);
        check(32'(closes - c0), 32'h0000_0000);
    endtask
    task automatic t_match;
        logic [7:0] ch [7] = '{8'h41, 8'h43, 8'h42, 8'h51, 8'h4a, 8'h41, 8'h41};
        logic [3:0] hit [7] = '{4'h9, 4'hc, 4'ha, 4'h0, 4'h8, 4'h9, 4'h9};
        logic [1:0] fl [7] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h1};
        logic [31:0] fc [7] = '{32'h0000_0234, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
            32'h0000_03b4, 32'h0000_0003, 32'h0000_0155};
        // Actions 00,01,11,00; then entry four 10; then entry one 11 alone; then all disabled
        for (int i = 0; i < 7; i++) begin
            if (fc[i] != 32'h0000_0000) wr(gap_match_pkg::ADDR_FLOW_CTRL, fc[i]);
            i_rx_char_source.send(ch[i]);
            @(posedge hclk);
            check(32'(match_hit), 32'(hit[i]));
            check(32'(flow_state), 32'(fl[i]));
        end
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        error_cnt++;
        end_of_test;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_regs;
        t_gap(20'h0_0000, 1'b0);
        t_gap(20'h0_0003, 1'b1);
        t_disabled;
        t_match;
        end_of_test;
    end
endmodule
